// ---- src/tlc_defines.svh ----
`ifndef TLC_DEFINES_SVH
`define TLC_DEFINES_SVH

// Register byte offsets, global
`define TLC_OFF_CTRL      10'h000
`define TLC_OFF_STATUS    10'h004
// Loop windows: loop 1 at 0x040, loop 2 at 0x080, word field in address bits 5:2
`define TLC_LOOP_REGION0  4'h1
`define TLC_LOOP_REGION1  4'h2
`define TLC_LF_SRC        4'h0
`define TLC_LF_TARGET     4'h1
`define TLC_LF_MODE       4'h2
`define TLC_LF_TABLE      4'h3
`define TLC_LF_RANGE      4'h4
`define TLC_LF_RATE       4'h5
`define TLC_LF_PROPORTIONAL_TERM      4'h6
`define TLC_LF_INTEGRAL_TERM      4'h7
`define TLC_LF_DERIVATIVE_TERM      4'h8
`define TLC_LF_RAMP       4'h9
`define TLC_LF_POWER      4'hA
`define TLC_LF_FULLSCALE  4'hB
// Statistics windows: channel c at 0x100 + c*0x20, word field in bits 4:2
`define TLC_STAT_REGION   2'h1
`define TLC_SF_MAX        3'h0
`define TLC_SF_VAR        3'h1
`define TLC_SF_SLOPE      3'h2
`define TLC_SF_OFFSET     3'h3
`define TLC_SF_COUNT      3'h4

// Field positions
`define TLC_CTRL_CLEAR_BIT   0
`define TLC_STAT_REJECT_BIT  0
`define TLC_STAT_VARIANT_BIT 1

// Control type codes
`define TLC_MODE_OFF      3'h0
`define TLC_MODE_PID      3'h1
`define TLC_MODE_MANUAL   3'h2
`define TLC_MODE_TABLE    3'h3
`define TLC_MODE_RAMP     3'h4

// Range codes for loop 1
`define TLC_RANGE_HI      2'h0
`define TLC_RANGE_MID     2'h1
`define TLC_RANGE_LOW     2'h2

// Limits (target, gains in 1/64 units; rate in 1/100 units per minute)
`define TLC_TARGET_MAX    16'hFA00
`define TLC_GAIN_MAX      16'hFA00
`define TLC_RATE_MAX      16'h2710
`define TLC_TABLE_MAX     3'h5

// Full-scale power in milliwatts
`define TLC_FS_HI_50      16'hC350
`define TLC_FS_MID_50     16'h1388
`define TLC_FS_LOW_50     16'h01F4
`define TLC_FS_HI_25      16'h61A8
`define TLC_FS_MID_25     16'h09C4
`define TLC_FS_LOW_25     16'h00FA
`define TLC_FS_LOOP2_HTR  16'h2710

// Reset values
`define TLC_RST_WORD16    16'h0000
`define TLC_RST_MODE      3'h0

// Timing: samples arriving per minute, divider steps
`define TLC_SAMPLES_PER_MIN 64'h000000000000003C
`define TLC_DIV_STEPS       7'h40

`endif

// ---- src/tlc_pkg.sv ----
package tlc_pkg;

	// Configuration handed to the control core of one loop
	typedef struct packed {
		logic        src;         // Feedback channel, 0 = A, 1 = B
		logic [15:0] target;      // Target temperature, 1/64 units
		logic [2:0]  mode;        // Control type code
		logic [2:0]  table_ix;    // Gain table index
		logic        table_valid; // Index in use (table mode)
		logic [1:0]  range;       // Heater range code
		logic [15:0] rate;        // Ramp rate, 1/100 units per minute
		logic [15:0] p_gain;      // Effective P, zero outside PID modes
		logic [15:0] i_gain;      // Effective I, zero outside PID modes
		logic [15:0] d_gain;      // Effective D, zero outside PID modes
		logic [15:0] full_mw;     // Full-scale output power, mW
	} tlc_loop_cfg_t;

	// State reported back by the control core of one loop
	typedef struct packed {
		logic        ramp_busy;   // Ramp in progress
		logic [15:0] power;       // Output level, 1/100 percent
	} tlc_loop_stat_t;

	// One temperature sample
	typedef struct packed {
		logic        valid;
		logic        ch;
		logic [15:0] temp;
	} tlc_sample_t;

	// Bus answer sequencing
	typedef enum logic [1:0] {
		TLC_BUS_IDLE,
		TLC_BUS_DIV,
		TLC_BUS_ACK
	} tlc_bus_state_t;

endpackage : tlc_pkg

// ---- src/tlc_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defines.svh"

module tlc_divider (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Request
	input  wire logic        start,
	input  wire logic [63:0] dividend,
	input  wire logic [63:0] divisor,
	// Answer
	output logic             done,
	output logic [63:0]      quotient
);

	logic [63:0] dvd_ff;  // Dividend shifting out, quotient shifting in
	logic [63:0] rem_ff;  // Partial remainder
	logic [63:0] dsr_ff;  // Held divisor
	logic [6:0]  cnt_ff;  // Steps left
	logic        done_ff; // Finish pulse
	logic [64:0] trial;   // Remainder with next bit
	logic        fits;    // Divisor fits into trial

	// Restoring step
	always_comb begin
		trial = {rem_ff, dvd_ff[63]};
		fits  = trial >= {1'b0, dsr_ff};
	end

	// One quotient bit per cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dvd_ff <= 64'h0;
			rem_ff <= 64'h0;
			dsr_ff <= 64'h0;
			cnt_ff <= 7'h0;
		end else if (start) begin
			dvd_ff <= dividend;
			rem_ff <= 64'h0;
			dsr_ff <= divisor;
			cnt_ff <= `TLC_DIV_STEPS;
		end else if (cnt_ff != 7'h0) begin
			rem_ff <= fits ? 64'(trial - {1'b0, dsr_ff}) : trial[63:0];
			dvd_ff <= {dvd_ff[62:0], fits};
			cnt_ff <= cnt_ff - 7'h1;
		end
	end

	// Done pulses in the cycle after the last step
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (cnt_ff == 7'h1) && !start;
		end
	end

	assign done     = done_ff;
	assign quotient = dvd_ff;

endmodule : tlc_divider

`default_nettype wire

// ---- src/tlc_loop_stats.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defines.svh"

module tlc_loop_stats #(
	parameter bit LOOP2_IS_HEATER = 1'b0
) (
	// Clock and reset
	input  wire logic                             mclk,
	input  wire logic                             nrst,
	// Avalon-MM slave
	input  wire logic [9:0]                       avs_address,
	input  wire logic                             avs_read,
	input  wire logic                             avs_write,
	input  wire logic [31:0]                      avs_writedata,
	input  wire logic [3:0]                       avs_byteenable,
	output logic [31:0]                           avs_readdata,
	output logic                                  avs_waitrequest,
	// Load strap pin, high for the 25 ohm heater load
	input  wire logic                             load_25ohm,
	// Temperature samples
	input  wire tlc_pkg::tlc_sample_t             sample,
	// Control core of each loop
	input  wire tlc_pkg::tlc_loop_stat_t [1:0]    loop_stat,
	output tlc_pkg::tlc_loop_cfg_t [1:0]          loop_cfg
);

	import tlc_pkg::*;

	// Loop settings, index 0 is loop 1
	logic        src_ff    [2];  // Feedback channel
	logic [15:0] target_ff [2];  // Target temperature
	logic [2:0]  mode_ff   [2];  // Control type
	logic [2:0]  table_ff  [2];  // Gain table index
	logic [1:0]  range_ff  [2];  // Heater range
	logic [15:0] rate_ff   [2];  // Ramp rate
	logic [15:0] pg_ff     [2];  // Proportional term
	logic [15:0] ig_ff     [2];  // Integral term
	logic [15:0] dg_ff     [2];  // Derivative term

	// Statistics accumulators per channel
	logic [9:0]  cnt_ff [2];     // Sample count, saturating
	logic [19:0] sx_ff  [2];     // Sum of sample index
	logic [29:0] sxx_ff [2];     // Sum of index squared
	logic [25:0] sy_ff  [2];     // Sum of temperature
	logic [41:0] syy_ff [2];     // Sum of temperature squared
	logic [35:0] sxy_ff [2];     // Sum of index times temperature
	logic [15:0] max_ff [2];     // Highest temperature

	// Bus side
	tlc_bus_state_t bus_ff;      // Answer sequencer
	logic [31:0]    rdata_ff;    // Registered read data
	logic           neg_ff;      // Quotient must be negated
	logic           reject_ff;   // Sticky: a setting was refused
	logic [31:0]    rd_mux;      // Current value at the address
	logic [31:0]    bemask;      // Byte lanes as bit mask
	logic [31:0]    wval;        // Merged write value
	logic           wr_go;       // Write takes effect this edge
	logic           stats_clr;   // Statistics clear pulse
	logic           hit_loop;    // Address in a loop window
	logic           lp;          // Addressed loop
	logic [3:0]     lf;          // Loop field
	logic           hit_ch;      // Address in a statistics window
	logic           ch;          // Addressed channel
	logic [2:0]     sf;          // Statistics field
	logic           val_ok;      // Write value within limits
	logic           div_rd;      // Read needs the divider
	logic [63:0]    num;         // Signed numerator
	logic [63:0]    den;         // Unsigned denominator
	logic [63:0]    mag;         // Numerator magnitude
	logic           div_done;    // Divider finished
	logic [63:0]    quot;        // Divider result
	logic [63:0]    sq;          // Signed quotient

	// Load strap synchroniser
	logic ld_s1_ff;
	logic ld_s2_ff;
	logic ld_s3_ff;
	logic ld_ff;                 // Accepted load setting

	// Address decode; loop index comes only from the address
	always_comb begin
		hit_loop = (avs_address[9:6] == `TLC_LOOP_REGION0) ||
		           (avs_address[9:6] == `TLC_LOOP_REGION1);
		lp       = avs_address[7];
		lf       = avs_address[5:2];
		hit_ch   = (avs_address[9:8] == `TLC_STAT_REGION) && (avs_address[7:6] == 2'h0);
		ch       = avs_address[5];
		sf       = avs_address[4:2];
		div_rd   = hit_ch && ((sf == `TLC_SF_VAR) || (sf == `TLC_SF_SLOPE) ||
		           (sf == `TLC_SF_OFFSET));
		bemask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wval     = (rd_mux & ~bemask) | (avs_writedata & bemask);
		wr_go    = (bus_ff == TLC_BUS_ACK) && avs_write;
		stats_clr = wr_go && (avs_address == `TLC_OFF_CTRL) && wval[`TLC_CTRL_CLEAR_BIT];
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0;
		if (avs_address == `TLC_OFF_STATUS) begin
			rd_mux[`TLC_STAT_REJECT_BIT]  = reject_ff;
			rd_mux[`TLC_STAT_VARIANT_BIT] = LOOP2_IS_HEATER;
		end else if (hit_loop) begin
			case (lf)
				`TLC_LF_SRC:       rd_mux[0]    = src_ff[lp];
				`TLC_LF_TARGET:    rd_mux[15:0] = target_ff[lp];
				`TLC_LF_MODE:      rd_mux[2:0]  = mode_ff[lp];
				`TLC_LF_TABLE:     rd_mux[2:0]  = table_ff[lp];
				`TLC_LF_RANGE:     rd_mux[1:0]  = range_ff[lp];
				`TLC_LF_RATE:      rd_mux[15:0] = rate_ff[lp];
				`TLC_LF_PROPORTIONAL_TERM:     rd_mux[15:0] = pg_ff[lp];
				`TLC_LF_INTEGRAL_TERM:     rd_mux[15:0] = ig_ff[lp];
				`TLC_LF_DERIVATIVE_TERM:     rd_mux[15:0] = dg_ff[lp];
				// Ramp shown only while the loop is in ramp mode, each loop alone
				`TLC_LF_RAMP:      rd_mux[0]    = loop_stat[lp].ramp_busy &&
				                   (mode_ff[lp] == `TLC_MODE_RAMP);
				`TLC_LF_POWER:     rd_mux[15:0] = loop_stat[lp].power;
				`TLC_LF_FULLSCALE: rd_mux[15:0] = loop_cfg[lp].full_mw;
				default:           rd_mux       = 32'h0;
			endcase
		end else if (hit_ch) begin
			case (sf)
				`TLC_SF_MAX:   rd_mux[15:0] = max_ff[ch];
				`TLC_SF_COUNT: rd_mux[9:0]  = cnt_ff[ch];
				default:       rd_mux       = 32'h0;
			endcase
		end
	end

	// Limit checks on a loop write
	always_comb begin
		case (lf)
			`TLC_LF_SRC:    val_ok = wval[31:1] == 31'h0;
			`TLC_LF_TARGET: val_ok = (wval[31:16] == 16'h0) && (wval[15:0] <= `TLC_TARGET_MAX);
			`TLC_LF_MODE:   val_ok = (wval[31:3] == 29'h0) && (wval[2:0] <= `TLC_MODE_RAMP);
			`TLC_LF_TABLE:  val_ok = (wval[31:3] == 29'h0) && (wval[2:0] <= `TLC_TABLE_MAX);
			// Loop 2 has one range only
			`TLC_LF_RANGE:  val_ok = (wval[31:2] == 30'h0) &&
			                (lp ? (wval[1:0] == `TLC_RANGE_HI) : (wval[1:0] <= `TLC_RANGE_LOW));
			`TLC_LF_RATE:   val_ok = (wval[31:16] == 16'h0) && (wval[15:0] <= `TLC_RATE_MAX);
			`TLC_LF_PROPORTIONAL_TERM,
			`TLC_LF_INTEGRAL_TERM,
			`TLC_LF_DERIVATIVE_TERM:  val_ok = (wval[31:16] == 16'h0) &&
			                (wval[15:0] <= `TLC_GAIN_MAX);
			default:        val_ok = 1'b1;
		endcase
	end

	// Loop settings written by software; refused values leave the setting alone
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int l = 0; l < 2; l++) begin
				src_ff[l]    <= 1'b0;
				target_ff[l] <= `TLC_RST_WORD16;
				mode_ff[l]   <= `TLC_RST_MODE;
				table_ff[l]  <= 3'h0;
				range_ff[l]  <= `TLC_RANGE_HI;
				rate_ff[l]   <= `TLC_RST_WORD16;
				pg_ff[l]     <= `TLC_RST_WORD16;
				ig_ff[l]     <= `TLC_RST_WORD16;
				dg_ff[l]     <= `TLC_RST_WORD16;
			end
		end else if (wr_go && hit_loop && val_ok) begin
			case (lf)
				`TLC_LF_SRC:    src_ff[lp]    <= wval[0];
				`TLC_LF_TARGET: target_ff[lp] <= wval[15:0];
				`TLC_LF_MODE:   mode_ff[lp]   <= wval[2:0];
				`TLC_LF_TABLE:  table_ff[lp]  <= wval[2:0];
				`TLC_LF_RANGE:  range_ff[lp]  <= wval[1:0];
				`TLC_LF_RATE:   rate_ff[lp]   <= wval[15:0];
				`TLC_LF_PROPORTIONAL_TERM:  pg_ff[lp]     <= wval[15:0];
				`TLC_LF_INTEGRAL_TERM:  ig_ff[lp]     <= wval[15:0];
				`TLC_LF_DERIVATIVE_TERM:  dg_ff[lp]     <= wval[15:0];
				default:        ;                                   // Read-only fields
			endcase
		end
	end

	// Refused-write flag; a new refusal wins over the clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reject_ff <= 1'b0;
		end else if (wr_go && hit_loop && !val_ok) begin
			reject_ff <= 1'b1;
		end else if (wr_go && (avs_address == `TLC_OFF_STATUS) && wval[`TLC_STAT_REJECT_BIT]) begin
			reject_ff <= 1'b0;
		end
	end

	// Load strap through three flops, taken when the last two agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ld_s1_ff <= 1'b0;
			ld_s2_ff <= 1'b0;
			ld_s3_ff <= 1'b0;
			ld_ff    <= 1'b0;
		end else begin
			ld_s1_ff <= load_25ohm;
			ld_s2_ff <= ld_s1_ff;
			ld_s3_ff <= ld_s2_ff;
			if (ld_s2_ff == ld_s3_ff) begin
				ld_ff <= ld_s3_ff;
			end
		end
	end

	// Settings handed to the control cores
	always_comb begin
		for (int l = 0; l < 2; l++) begin
			logic pid_on;
			pid_on = (mode_ff[l] == `TLC_MODE_PID) || (mode_ff[l] == `TLC_MODE_TABLE) ||
			         (mode_ff[l] == `TLC_MODE_RAMP);
			loop_cfg[l].src         = src_ff[l];
			loop_cfg[l].target      = target_ff[l];
			loop_cfg[l].mode        = mode_ff[l];
			loop_cfg[l].table_ix    = table_ff[l];
			loop_cfg[l].table_valid = mode_ff[l] == `TLC_MODE_TABLE;
			loop_cfg[l].range       = range_ff[l];
			loop_cfg[l].rate        = rate_ff[l];
			loop_cfg[l].p_gain      = pid_on ? pg_ff[l] : 16'h0;
			loop_cfg[l].i_gain      = pid_on ? ig_ff[l] : 16'h0;
			loop_cfg[l].d_gain      = pid_on ? dg_ff[l] : 16'h0;
			loop_cfg[l].full_mw     = 16'h0;
		end
		// Loop 1 power ceiling by range and load
		case (range_ff[0])
			`TLC_RANGE_HI:  loop_cfg[0].full_mw = ld_ff ? `TLC_FS_HI_25 : `TLC_FS_HI_50;
			`TLC_RANGE_MID: loop_cfg[0].full_mw = ld_ff ? `TLC_FS_MID_25 : `TLC_FS_MID_50;
			`TLC_RANGE_LOW: loop_cfg[0].full_mw = ld_ff ? `TLC_FS_LOW_25 : `TLC_FS_LOW_50;
			default:        loop_cfg[0].full_mw = 16'h0;
		endcase
		// Loop 2: voltage output has no power ceiling, heater output 10000 mW when LOOP2_IS_HEATER is set
		loop_cfg[1].full_mw = LOOP2_IS_HEATER ? `TLC_FS_LOOP2_HTR : 16'h0;
	end

	// Accumulators; the clear acts on every channel at once and wins over a sample
	for (genvar c = 0; c < 2; c++) begin : g_stats
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				cnt_ff[c] <= 10'h0;
				sx_ff[c]  <= 20'h0;
				sxx_ff[c] <= 30'h0;
				sy_ff[c]  <= 26'h0;
				syy_ff[c] <= 42'h0;
				sxy_ff[c] <= 36'h0;
				max_ff[c] <= 16'h0;
			end else if (stats_clr) begin
				cnt_ff[c] <= 10'h0;
				sx_ff[c]  <= 20'h0;
				sxx_ff[c] <= 30'h0;
				sy_ff[c]  <= 26'h0;
				syy_ff[c] <= 42'h0;
				sxy_ff[c] <= 36'h0;
				max_ff[c] <= 16'h0;
			end else if (sample.valid && (sample.ch == c[0]) && (cnt_ff[c] != 10'h3FF)) begin
				cnt_ff[c] <= cnt_ff[c] + 10'h1;
				sx_ff[c]  <= sx_ff[c] + 20'(cnt_ff[c]);
				sxx_ff[c] <= sxx_ff[c] + 30'(cnt_ff[c] * cnt_ff[c]);
				sy_ff[c]  <= sy_ff[c] + 26'(sample.temp);
				syy_ff[c] <= syy_ff[c] + 42'(sample.temp * sample.temp);
				sxy_ff[c] <= sxy_ff[c] + 36'(cnt_ff[c] * sample.temp);
				if ((cnt_ff[c] == 10'h0) || (sample.temp > max_ff[c])) begin
					max_ff[c] <= sample.temp;
				end
			end
		end
	end

	// Numerator and denominator of the addressed statistic
	always_comb begin
		logic [63:0] n;
		logic [63:0] sx;
		logic [63:0] sxx;
		logic [63:0] sy;
		logic [63:0] syy;
		logic [63:0] sxy;
		n   = 64'(cnt_ff[ch]);
		sx  = 64'(sx_ff[ch]);
		sxx = 64'(sxx_ff[ch]);
		sy  = 64'(sy_ff[ch]);
		syy = 64'(syy_ff[ch]);
		sxy = 64'(sxy_ff[ch]);
		case (sf)
			`TLC_SF_VAR: begin
				num = 64'(n * syy) - 64'(sy * sy);
				den = 64'(n * n);
			end
			`TLC_SF_SLOPE: begin
				num = 64'((64'(n * sxy) - 64'(sx * sy)) * `TLC_SAMPLES_PER_MIN);
				den = 64'(n * sxx) - 64'(sx * sx);
			end
			`TLC_SF_OFFSET: begin
				num = 64'(sxx * sy) - 64'(sx * sxy);
				den = 64'(n * sxx) - 64'(sx * sx);
			end
			default: begin
				num = 64'h0;
				den = 64'h0;
			end
		endcase
		mag = num[63] ? 64'(-num) : num;
		sq  = neg_ff ? 64'(-quot) : quot;
	end

	// Shared divider for variance, slope and offset
	tlc_divider u_div (
		.mclk     (mclk),
		.nrst     (nrst),
		.start    ((bus_ff == TLC_BUS_IDLE) && avs_read && div_rd && (den != 64'h0)),
		.dividend (mag),
		.divisor  (den),
		.done     (div_done),
		.quotient (quot)
	);

	// Answer sequencer: one wait cycle, or the divide time for derived statistics
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_ff   <= TLC_BUS_IDLE;
			rdata_ff <= 32'h0;
			neg_ff   <= 1'b0;
		end else begin
			case (bus_ff)
				TLC_BUS_IDLE: begin
					if (avs_read && div_rd && (den != 64'h0)) begin
						neg_ff <= num[63];
						bus_ff <= TLC_BUS_DIV;
					end else if (avs_read || avs_write) begin
						rdata_ff <= avs_read ? rd_mux : 32'h0;
						bus_ff   <= TLC_BUS_ACK;
					end
				end
				TLC_BUS_DIV: begin
					if (div_done) begin
						rdata_ff <= sq[31:0];
						bus_ff   <= TLC_BUS_ACK;
					end
				end
				TLC_BUS_ACK: bus_ff <= TLC_BUS_IDLE;
				default:     bus_ff <= TLC_BUS_IDLE;
			endcase
		end
	end

	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = bus_ff != TLC_BUS_ACK;

endmodule : tlc_loop_stats

`default_nettype wire

// ---- test/tlc_loop_stats_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defines.svh"

// Watches the ports of the loop and statistics block
module tlc_loop_stats_properties (
	// Clock and reset
	input wire logic                          mclk,
	input wire logic                          nrst,
	// Bus
	input wire logic [9:0]                    avs_address,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic [31:0]                   avs_writedata,
	input wire logic [3:0]                    avs_byteenable,
	input wire logic [31:0]                   avs_readdata,
	input wire logic                          avs_waitrequest,
	// Strap, samples, control cores
	input wire logic                          load_25ohm,
	input wire tlc_pkg::tlc_sample_t          sample,
	input wire tlc_pkg::tlc_loop_stat_t [1:0] loop_stat,
	input wire tlc_pkg::tlc_loop_cfg_t [1:0]  loop_cfg
);
	import tlc_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_ans_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_ans_one: assert property (p_ans_one) else $error("answer held too long");
	property p_idle; !avs_read && !avs_write |-> avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_plain;
		$rose(avs_read || avs_write) && avs_address < 10'h100 |=> !avs_waitrequest;
	endproperty
	a_plain: assert property (p_plain) else $error("plain access late");
	property p_tbl;
		loop_cfg[0].table_valid == (loop_cfg[0].mode == `TLC_MODE_TABLE)
			&& loop_cfg[1].table_valid == (loop_cfg[1].mode == `TLC_MODE_TABLE);
	endproperty
	a_tbl: assert property (p_tbl) else $error("table index use wrong");
	property p_gate;
		!(loop_cfg[0].mode inside {`TLC_MODE_PID, `TLC_MODE_TABLE, `TLC_MODE_RAMP})
			|-> loop_cfg[0].p_gain == 0 && loop_cfg[0].i_gain == 0 && loop_cfg[0].d_gain == 0;
	endproperty
	a_gate: assert property (p_gate) else $error("gains outside pid");
	property p_lim;
		loop_cfg[0].target <= 16'hFA00 && loop_cfg[1].rate <= 16'h2710
			&& loop_cfg[0].rate <= 16'h2710 && loop_cfg[1].table_ix <= 3'h5;
	endproperty
	a_lim: assert property (p_lim) else $error("setting beyond limit");
	property p_l2; loop_cfg[1].full_mw == 16'h0000 && loop_cfg[1].range == 2'h0; endproperty
	a_l2: assert property (p_l2) else $error("loop 2 output wrong");
	property p_low;
		loop_cfg[0].range == `TLC_RANGE_LOW
			|-> loop_cfg[0].full_mw == 16'h01F4 || loop_cfg[0].full_mw == 16'h00FA;
	endproperty
	a_low: assert property (p_low) else $error("low range power wrong");
	property p_pwr;
		$rose(avs_read) && avs_address == 10'h068 && $stable(loop_stat[0].power)
			|=> !avs_waitrequest && avs_readdata[15:0] == $past(loop_stat[0].power);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power readback wrong");
	c_div: cover property ($rose(avs_read) && avs_address == 10'h104 ##1 avs_waitrequest[*8]);
	c_ramp: cover property (!avs_waitrequest && avs_readdata[0] && avs_address == 10'h064);
	c_ref: cover property (avs_write && !avs_waitrequest && avs_writedata == 32'h5);
endmodule : tlc_loop_stats_properties

bind tlc_loop_stats tlc_loop_stats_properties i_tlc_loop_stats_properties (
	.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .load_25ohm(load_25ohm),
	.sample(sample), .loop_stat(loop_stat), .loop_cfg(loop_cfg));
`default_nettype wire

// ---- test/tlc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Sensor front end and both loop control cores
module tlc_core_model (
	// Clock
	input  wire logic                         mclk,
	// Toward the block
	output var tlc_pkg::tlc_sample_t          sample,
	output var tlc_pkg::tlc_loop_stat_t [1:0] loop_stat
);
	import tlc_pkg::*;
	// Quiet until told otherwise
	initial begin
		sample = '0;
		loop_stat = '0;
	end
	// One sample, valid for exactly one cycle
	task push(input logic c, input logic [15:0] t);
		@(posedge mclk);
		sample <= '{1'b1, c, t};
		@(posedge mclk);
		sample <= '0;
	endtask : push
	// Ramp flag and power of one loop, each loop on its own
	task set_loop(input int i, input logic b, input logic [15:0] p);
		@(posedge mclk);
		loop_stat[i] <= '{b, p};
	endtask : set_loop
endmodule : tlc_core_model
`default_nettype wire

// ---- test/temp_loop_config_and_stats_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module temp_loop_config_and_stats_bench;
	import tlc_pkg::*;
	logic mclk = 0, nrst = 0, ld = 0, rd = 0, wr = 0, wreq;
	logic [9:0] adr = 0;
	logic [31:0] wd = 0, rdata, d;
	tlc_sample_t smp;
	tlc_loop_stat_t [1:0] lst;
	tlc_loop_cfg_t [1:0] cfg;
	int failures = 0, compares = 0, cyc = 0;
	logic [9:0] la[6] = '{10'h044, 10'h054, 10'h058, 10'h05C, 10'h060, 10'h04C};
	logic [31:0] lm[6] = '{32'hFA00, 32'h2710, 32'hFA00, 32'hFA00, 32'hFA00, 32'h5};
	logic [15:0] fs[2][3] = '{'{16'hC350, 16'h1388, 16'h01F4}, '{16'h61A8, 16'h09C4, 16'h00FA}};

	always #50 mclk = ~mclk;
	tlc_loop_stats i_tlc_loop_stats (.mclk(mclk), .nrst(nrst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .load_25ohm(ld), .sample(smp),
		.loop_stat(lst), .loop_cfg(cfg));
	tlc_core_model i_tlc_core_model (.mclk(mclk), .sample(smp), .loop_stat(lst));

	// Compare and count
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// One bus access, held until waitrequest is seen low; only the hang guard ends a stuck wait
	task xfer(input logic w, input logic [9:0] a, input logic [31:0] v);
		@(posedge mclk);
		adr <= a;
		wd <= v;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge mclk);
		end while (wreq !== 1'b0);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : xfer
	// Read and compare
	task rc(input logic [9:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), d, e);
	endtask : rc
	// Counts and verdict
	task finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			finish_test;
		end
	end

	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		// Reset values
		rc(10'h048, 32'h0);
		rc(10'h06C, 32'hC350);
		rc(10'h004, 32'h0);
		rc(10'h0AC, 32'h0);
		// Several settings to loop 1 only
		xfer(1, 10'h040, 32'h1);
		xfer(1, 10'h044, 32'h1EDA);
		xfer(1, 10'h058, 32'h1E00);
		rc(10'h040, 32'h1);
		rc(10'h044, 32'h1EDA);
		rc(10'h058, 32'h1E00);
		rc(10'h080, 32'h0);
		// Every control type, then an unknown one refused
		for (int m = 0; m < 5; m++) begin
			xfer(1, 10'h088, m);
			rc(10'h088, m);
		end
		xfer(1, 10'h088, 32'h5);
		rc(10'h088, 32'h4);
		rc(10'h004, 32'h1);
		xfer(1, 10'h004, 32'h1);
		rc(10'h004, 32'h0);
		// Limits: top value kept, one above refused
		for (int i = 0; i < 6; i++) begin
			xfer(1, la[i], lm[i]);
			xfer(1, la[i], lm[i] + 1);
			rc(la[i], lm[i]);
			rc(10'h004, 32'h1);
			xfer(1, 10'h004, 32'h1);
		end
		// Ranges under both loads
		for (int l = 0; l < 2; l++) begin
			ld <= l[0];
			repeat (6) @(posedge mclk);
			for (int r = 0; r < 3; r++) begin
				xfer(1, 10'h050, r);
				rc(10'h06C, fs[l][r]);
			end
		end
		// Ramp status and power, per loop
		i_tlc_core_model.set_loop(0, 1'b1, 16'h1D4C);
		i_tlc_core_model.set_loop(1, 1'b0, 16'h0BB8);
		xfer(1, 10'h048, 32'h4);
		rc(10'h064, 32'h1);
		rc(10'h0A4, 32'h0);
		rc(10'h068, 32'h1D4C);
		rc(10'h0A8, 32'h0BB8);
		xfer(1, 10'h048, 32'h2);
		rc(10'h064, 32'h0);
		chk("p gated", {16'h0, cfg[0].p_gain}, 32'h0);
		// Statistics on a straight line and one other channel
		for (int x = 0; x < 4; x++) i_tlc_core_model.push(1'b0, 16'h0100 + 16'(x * 64));
		i_tlc_core_model.push(1'b1, 16'h0050);
		rc(10'h100, 32'h1C0);
		rc(10'h104, 32'h1400);
		rc(10'h108, 32'hF00);
		rc(10'h10C, 32'h100);
		rc(10'h120, 32'h50);
		rc(10'h110, 32'h4);
		// Falling line on channel B: 80 then 48, so negative slope
		i_tlc_core_model.push(1'b1, 16'h0030);
		rc(10'h124, 32'h100);
		rc(10'h128, 32'hFFFFF880);
		rc(10'h12C, 32'h50);
		rc(10'h120, 32'h50);
		xfer(1, 10'h000, 32'h1);
		rc(10'h110, 32'h0);
		rc(10'h100, 32'h0);
		rc(10'h104, 32'h0);
		rc(10'h120, 32'h0);
		finish_test;
	end
endmodule : temp_loop_config_and_stats_bench
`default_nettype wire
